// ==== tscc_top.sv ====
// Configuration and control of the tilt sensor: command decode, set input
// qualification, origin, direction, teach-in span and output pacing.
// Assumes commands arrive already framed, one register write per command.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module tscc_top #(
	parameter int unsigned CYC_PER_US = tscc_pkg::CLK_MHZ,
	// Divides the hold and period counts, not the baud divisor; 1 outside simulation
	parameter int unsigned TIME_DIV = 1
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Register port
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// Sensor angle and set pins
	input wire logic [15:0] i_angle,
	input wire logic i_origin_teach_input,
	input wire logic i_direction_span_input,
	// Serial link control
	output logic o_boot,
	output logic o_tx_tick,
	output logic [2:0] o_baud_code,
	output logic [31:0] o_baud_div,
	output logic o_reply_valid,
	output logic [7:0] o_reply_char,
	// Positions
	output logic [15:0] o_position,
	output logic [15:0] o_analog_pos,
	output logic [15:0] o_analog_span,
	output logic o_ccw,
	output logic o_mode_teach
);

	localparam logic [31:0] HOLD_CYC =
		32'(tscc_pkg::HOLD_US) * 32'(CYC_PER_US) / 32'(TIME_DIV);

	tscc_pkg::tscc_state_s r;
	tscc_pkg::tscc_state_s n;

	function automatic logic [4:0] dig_dec(input logic [7:0] c);
		if (c >= tscc_pkg::CHAR_ZERO && c <= tscc_pkg::CHAR_NINE) begin
			return {1'b1, 4'(c - tscc_pkg::CHAR_ZERO)};
		end
		return 5'h00;
	endfunction : dig_dec

	function automatic logic [31:0] per_cycles(input logic [2:0] code);
		logic [31:0] us;
		case (code)
			3'h1: us = 32'(tscc_pkg::PER1_US);
			3'h2: us = 32'(tscc_pkg::PER2_US);
			3'h3: us = 32'(tscc_pkg::PER3_US);
			3'h4: us = 32'(tscc_pkg::PER4_US);
			3'h5: us = 32'(tscc_pkg::PER5_US);
			3'h6: us = 32'(tscc_pkg::PER6_US);
			default: us = 32'(tscc_pkg::PER7_US);
		endcase
		return us * 32'(CYC_PER_US) / 32'(TIME_DIV);
	endfunction : per_cycles

	function automatic logic [31:0] baud_div(input logic [2:0] code);
		int unsigned b;
		case (code)
			3'h0: b = tscc_pkg::BAUD0;
			3'h1: b = tscc_pkg::BAUD1;
			3'h2: b = tscc_pkg::BAUD2;
			3'h3: b = tscc_pkg::BAUD3;
			3'h4: b = tscc_pkg::BAUD4;
			3'h5: b = tscc_pkg::BAUD5;
			default: b = tscc_pkg::BAUD6;
		endcase
		return 32'(tscc_pkg::CLK_HZ / b);
	endfunction : baud_div

	always_comb begin
		logic [4:0] dig;
		logic err;
		logic teach;
		logic [15:0] rel;
		logic [15:0] len;
		dig = dig_dec(i_wdata[tscc_pkg::CMD_ARG_LSB +: 8]);
		err = 1'b0;
		teach = (r.mode == tscc_pkg::MODE_TEACH);
		rel = 16'h0000;
		len = 16'h0000;
		n = r;
		n.lock = 2'b00;
		n.tx_tick = 1'b0;
		n.boot = 1'b0;
		n.reply_valid = 1'b0;
		n.rdata = 32'h0000_0000;
		// Pin synchronisers
		n.s_a = {i_direction_span_input, i_origin_teach_input};
		n.s_b = r.s_a;
		// Hold timers; a lock is raised the cycle after release
		for (int i = 0; i < 2; i++) begin
			if (r.s_b[i]) begin
				if (r.hold_cnt[i] != HOLD_CYC) begin
					n.hold_cnt[i] = r.hold_cnt[i] + 32'h1;
				end
			end else begin
				n.hold_cnt[i] = 32'h0;
				n.lock[i] = (r.hold_cnt[i] == HOLD_CYC);
			end
		end
		// Locked set inputs; they never touch the mode
		if (r.lock[0]) begin
			if (!teach) begin
				n.origin = i_angle;
			end else begin
				n.span_start = i_angle;
				n.span_first = 1'b1;
				n.span_set = 1'b0;
			end
		end
		if (r.lock[1] && teach && r.span_first) begin
			n.span_end = i_angle;
			n.span_set = 1'b1;
			n.span_first = 1'b0;
			n.origin = r.span_start;
			n.span_ccw = (i_angle - r.span_start) >= 16'h8000;
		end
		// Output pacing
		n.booted = 1'b1;
		n.boot = !r.booted;
		if (r.booted) begin
			if (r.per_cnt >= per_cycles(r.period_code) - 32'h1) begin
				n.per_cnt = 32'h0;
				n.tx_tick = 1'b1;
			end else begin
				n.per_cnt = r.per_cnt + 32'h1;
			end
		end
		// Commands, one per write
		if (i_wr && i_addr == tscc_pkg::ADDR_CMD) begin
			case (i_wdata[tscc_pkg::CMD_CODE_LSB +: 8])
				tscc_pkg::CMD_PERIOD: begin
					if (dig[4] && dig[3:0] >= 4'h1 && dig[3:0] <= 4'h7) begin
						n.period_code = dig[2:0];
						n.per_cnt = 32'h0;
					end else begin
						err = 1'b1;
					end
				end
				tscc_pkg::CMD_BAUD: begin
					if (dig[4] && dig[3:0] <= 4'h6) begin
						n.baud_code = dig[2:0];
					end else begin
						err = 1'b1;
					end
				end
				tscc_pkg::CMD_TEACH: begin
					if (dig[4] && dig[3:0] <= 4'h1) begin
						n.mode = dig[0] ? tscc_pkg::MODE_TEACH :
							tscc_pkg::MODE_PRESET;
					end else begin
						err = 1'b1;
					end
				end
				tscc_pkg::CMD_COMPL: begin
					if (dig[4] && dig[3:0] <= 4'h2) begin
						n.compl = dig[1:0];
					end else begin
						err = 1'b1;
					end
				end
				tscc_pkg::CMD_SETORG: begin
					n.origin = i_angle;
					if (teach) begin
						n.span_start = i_angle;
						n.span_first = 1'b1;
					end
				end
				tscc_pkg::CMD_CLRORG: begin
					n.origin = tscc_pkg::ORIGIN_DEF;
				end
				tscc_pkg::CMD_SETMAX: begin
					if (teach) begin
						if (!r.span_first && !r.span_set) begin
							n.span_start = r.origin;
						end
						n.span_end = i_angle;
						n.span_set = 1'b1;
						n.span_first = 1'b0;
						n.span_ccw = (i_angle - n.span_start) >= 16'h8000;
					end else begin
						err = 1'b1;
					end
				end
				tscc_pkg::CMD_CLRMAX: begin
					n.span_set = 1'b0;
					n.span_first = 1'b0;
					n.span_start = 16'h0000;
					n.span_end = 16'h0000;
				end
				default: err = 1'b1;
			endcase
			if (err) begin
				n.reply_valid = 1'b1;
				n.reply_char = tscc_pkg::CHAR_ERR;
			end
		end
		n.baud_div = baud_div(n.baud_code);
		// Direction and serial position, never limited by the span
		n.ccw = (n.compl == tscc_pkg::COMPL_CCW) ||
			(n.compl == tscc_pkg::COMPL_DIRECTION_SPAN_INPUT &&
			n.mode == tscc_pkg::MODE_PRESET && r.s_b[1]);
		n.position = n.ccw ? n.origin - i_angle :
			i_angle - n.origin;
		// Analog scaling only from a teach span in teach mode
		if (n.mode == tscc_pkg::MODE_TEACH && n.span_set) begin
			rel = n.span_ccw ? n.span_start - i_angle :
				i_angle - n.span_start;
			len = n.span_ccw ? n.span_start - n.span_end :
				n.span_end - n.span_start;
			n.analog_pos = (rel > len) ? len : rel;
			n.analog_span = len;
		end else begin
			n.analog_pos = n.position;
			n.analog_span = tscc_pkg::SPAN_FULL;
		end
		// Register reads
		if (i_rd) begin
			if (i_addr == tscc_pkg::ADDR_CMD) begin
				n.rdata = {24'h000000, r.reply_char};
			end else if (i_addr == tscc_pkg::ADDR_CONFIG) begin
				n.rdata[tscc_pkg::CFG_PERIOD_LSB +: 3] = r.period_code;
				n.rdata[tscc_pkg::CFG_BAUD_LSB +: 3] = r.baud_code;
				n.rdata[tscc_pkg::CFG_MODE_LSB] = teach;
				n.rdata[tscc_pkg::CFG_COMPL_LSB +: 2] = r.compl;
			end else if (i_addr == tscc_pkg::ADDR_ORIGIN) begin
				n.rdata = {16'h0000, r.origin};
			end else if (i_addr == tscc_pkg::ADDR_SPAN) begin
				n.rdata = {r.span_end, r.span_start};
			end else if (i_addr == tscc_pkg::ADDR_STATUS) begin
				n.rdata = {26'h0, r.s_b, r.ccw, r.span_ccw,
					r.span_first, r.span_set};
			end else if (i_addr == tscc_pkg::ADDR_POS) begin
				n.rdata = {16'h0000, r.position};
			end else begin
				n.rdata = 32'h0000_0000;
			end
		end
		if (!i_rstn) begin
			n = '0;
			n.mode = tscc_pkg::MODE_PRESET;
			n.period_code = tscc_pkg::PERIOD_DEF;
			n.baud_code = tscc_pkg::BAUD_DEF;
			n.baud_div = baud_div(tscc_pkg::BAUD_DEF);
			n.compl = tscc_pkg::COMPL_CW;
			n.origin = tscc_pkg::ORIGIN_DEF;
			n.analog_span = tscc_pkg::SPAN_FULL;
		end
	end

	always_ff @(posedge i_clk) begin
		r <= n;
	end

	assign o_rdata = r.rdata;
	assign o_boot = r.boot;
	assign o_tx_tick = r.tx_tick;
	assign o_baud_code = r.baud_code;
	assign o_baud_div = r.baud_div;
	assign o_reply_valid = r.reply_valid;
	assign o_reply_char = r.reply_char;
	assign o_position = r.position;
	assign o_analog_pos = r.analog_pos;
	assign o_analog_span = r.analog_span;
	assign o_ccw = r.ccw;
	assign o_mode_teach = r.mode[1];

	default clocking assert_clk @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);

	period_bound_a: assert property (
		r.per_cnt < per_cycles(r.period_code))
		else $error("period counter past interval");

	baud_apply_a: assert property (
		(i_wr && i_addr == tscc_pkg::ADDR_CMD &&
		i_wdata[15:8] == tscc_pkg::CMD_BAUD && dig_dec(i_wdata[7:0]) >= 5'h10
		&& dig_dec(i_wdata[7:0]) <= 5'h16)
		|=> o_baud_code == $past(i_wdata[2:0]) &&
		o_baud_div == baud_div($past(i_wdata[2:0])))
		else $error("baud not applied at once");

	mode_reset_a: assert property (
		!$past(i_rstn) |-> r.mode == tscc_pkg::MODE_PRESET &&
		r.period_code == tscc_pkg::PERIOD_DEF)
		else $error("wrong state after reset");

	setorg_zero_a: assert property (
		(i_wr && i_addr == tscc_pkg::ADDR_CMD &&
		i_wdata[15:8] == tscc_pkg::CMD_SETORG)
		|=> o_position == 16'h0000 && r.origin == $past(i_angle))
		else $error("set origin not taken");

	clrorg_def_a: assert property (
		(i_wr && i_addr == tscc_pkg::ADDR_CMD &&
		i_wdata[15:8] == tscc_pkg::CMD_CLRORG && !r.lock[0])
		|=> r.origin == tscc_pkg::ORIGIN_DEF)
		else $error("clear origin not taken");

	dir_direction_span_input_a: assert property (
		(r.compl == tscc_pkg::COMPL_DIRECTION_SPAN_INPUT && r.mode == tscc_pkg::MODE_PRESET &&
		!i_wr) |=> o_ccw == $past(r.s_b[1]))
		else $error("direction input not followed");

	hold_lock_a: assert property (
		r.lock[0] |-> $past(r.hold_cnt[0]) == HOLD_CYC && !$past(r.s_b[0]))
		else $error("lock without full hold");

	release_lock_a: assert property (
		(r.s_b[1] && r.hold_cnt[1] == HOLD_CYC) |=> !r.lock[1])
		else $error("lock while input held");

	bad_arg_a: assert property (
		(i_wr && i_addr == tscc_pkg::ADDR_CMD &&
		i_wdata[15:8] == tscc_pkg::CMD_PERIOD &&
		dig_dec(i_wdata[7:0]) == 5'h00)
		|=> o_reply_valid && o_reply_char == tscc_pkg::CHAR_ERR &&
		r.period_code == $past(r.period_code))
		else $error("bad parameter not refused");

	teach_done_a: assert property (
		(r.lock[1] && r.mode == tscc_pkg::MODE_TEACH && r.span_first && !i_wr)
		|=> r.span_set && r.origin == $past(r.span_start))
		else $error("teach completion wrong");

endmodule : tscc_top

`default_nettype wire

// ==== tscc_pkg.sv ====
// Constants, command codes, mode encoding and the state record of the
// tilt sensor configuration and control block.
// Assumes a 250 MHz system clock.
`default_nettype none

package tscc_pkg;

	// Register byte offsets
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_CONFIG = 8'h04;
	localparam logic [7:0] ADDR_ORIGIN = 8'h08;
	localparam logic [7:0] ADDR_SPAN = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [7:0] ADDR_POS = 8'h14;

	// Field positions in the command and configuration words
	localparam int CMD_ARG_LSB = 0;
	localparam int CMD_CODE_LSB = 8;
	localparam int CFG_PERIOD_LSB = 0;
	localparam int CFG_BAUD_LSB = 4;
	localparam int CFG_MODE_LSB = 8;
	localparam int CFG_COMPL_LSB = 10;

	typedef enum logic [7:0] {
		CMD_PERIOD = 8'h01,
		CMD_BAUD = 8'h02,
		CMD_TEACH = 8'h03,
		CMD_COMPL = 8'h04,
		CMD_SETORG = 8'h05,
		CMD_CLRORG = 8'h06,
		CMD_SETMAX = 8'h07,
		CMD_CLRMAX = 8'h08
	} tscc_cmd_e;

	typedef enum logic [1:0] {
		MODE_PRESET = 2'b01,
		MODE_TEACH = 2'b10
	} tscc_mode_e;

	// Direction settings
	localparam logic [1:0] COMPL_CW = 2'h0;
	localparam logic [1:0] COMPL_CCW = 2'h1;
	localparam logic [1:0] COMPL_DIRECTION_SPAN_INPUT = 2'h2;

	// Reset values
	localparam logic [2:0] PERIOD_DEF = 3'h2;
	localparam logic [2:0] BAUD_DEF = 3'h2;
	localparam logic [15:0] ORIGIN_DEF = 16'h0000;
	localparam logic [15:0] SPAN_FULL = 16'hFFFF;

	// ASCII
	localparam logic [7:0] CHAR_ZERO = 8'h30;
	localparam logic [7:0] CHAR_NINE = 8'h39;
	localparam logic [7:0] CHAR_ERR = 8'h45;

	// Timing, in microseconds as printed in ms, and the clock
	localparam int unsigned CLK_HZ = 250000000;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned HOLD_US = 100000;
	localparam int unsigned PER1_US = 62500;
	localparam int unsigned PER2_US = 100000;
	localparam int unsigned PER3_US = 200000;
	localparam int unsigned PER4_US = 500000;
	localparam int unsigned PER5_US = 1000000;
	localparam int unsigned PER6_US = 5000000;
	localparam int unsigned PER7_US = 10000000;

	// Line speeds in baud
	localparam int unsigned BAUD0 = 2400;
	localparam int unsigned BAUD1 = 4800;
	localparam int unsigned BAUD2 = 9600;
	localparam int unsigned BAUD3 = 19200;
	localparam int unsigned BAUD4 = 38400;
	localparam int unsigned BAUD5 = 57600;
	localparam int unsigned BAUD6 = 115200;

	typedef struct packed {
		logic [1:0] s_a;
		logic [1:0] s_b;
		logic [1:0][31:0] hold_cnt;
		logic [1:0] lock;
		logic [2:0] period_code;
		logic [2:0] baud_code;
		logic [31:0] baud_div;
		tscc_mode_e mode;
		logic [1:0] compl;
		logic [15:0] origin;
		logic [15:0] span_start;
		logic [15:0] span_end;
		logic span_first;
		logic span_set;
		logic span_ccw;
		logic ccw;
		logic [31:0] per_cnt;
		logic tx_tick;
		logic booted;
		logic boot;
		logic [15:0] position;
		logic [15:0] analog_pos;
		logic [15:0] analog_span;
		logic reply_valid;
		logic [7:0] reply_char;
		logic [31:0] rdata;
	} tscc_state_s;

endpackage : tscc_pkg

`default_nettype wire

// ==== tscc_operator.sv ====
// Operator model that drives the two set pins of the tilt sensor.
// Assumes the bench calls one task at a time from a single process.
`timescale 1ns/1ps
`default_nettype none

module tscc_operator (
	// Clock
	input wire logic i_clk,
	// Set pins
	output logic o_pin1,
	output logic o_pin2
);
	initial begin
		o_pin1 = 1'b0;
		o_pin2 = 1'b0;
	end

	// Pulse one pin for n cycles; pin 1 is taught before pin 2
	task automatic hold(input int pin, input int n);
		@(posedge i_clk);
		o_pin1 <= (pin == 1) ? 1'b1 : o_pin1;
		o_pin2 <= (pin == 2) ? 1'b1 : o_pin2;
		repeat (n) @(posedge i_clk);
		o_pin1 <= 1'b0;
		o_pin2 <= 1'b0;
	endtask : hold

	// Steady level on the direction pin
	task automatic level(input logic v);
		@(posedge i_clk);
		o_pin2 <= v;
	endtask : level
endmodule : tscc_operator

`default_nettype wire

// ==== tscc_top_test.sv ====
// Self-checking bench of the tilt sensor configuration block.
// Assumes CYC_PER_US of 1 and TIME_DIV of 100 so that hold and period
// counts stay short.
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
	$display("[ERR] %s exp %0h got %0h", nm, e, g); end end

module tscc_top_test;
	logic i_clk, i_rstn, i_wr, i_rd, o_boot, o_tx_tick, o_reply_valid;
	logic o_ccw, o_mode_teach, pin1, pin2;
	logic [7:0] i_addr, o_reply_char;
	logic [31:0] i_wdata, o_rdata, o_baud_div, d;
	logic [15:0] i_angle, o_position, o_analog_pos, o_analog_span;
	logic [2:0] o_baud_code;
	int errors = 0;
	int comparisons = 0;
	localparam int unsigned TDIV = 100;

	tscc_top #(.CYC_PER_US(1), .TIME_DIV(TDIV)) i_tscc_top (
		.i_clk(i_clk), .i_rstn(i_rstn),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_angle(i_angle), .i_origin_teach_input(pin1),
		.i_direction_span_input(pin2), .o_boot(o_boot),
		.o_tx_tick(o_tx_tick), .o_baud_code(o_baud_code),
		.o_baud_div(o_baud_div), .o_reply_valid(o_reply_valid),
		.o_reply_char(o_reply_char), .o_position(o_position),
		.o_analog_pos(o_analog_pos), .o_analog_span(o_analog_span),
		.o_ccw(o_ccw), .o_mode_teach(o_mode_teach));
	tscc_operator i_tscc_operator (.i_clk(i_clk), .o_pin1(pin1),
		.o_pin2(pin2));

	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	task automatic test_done();
		if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : test_done

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clk);
		i_wr <= 1'b0;
		#1;
	endtask : bus_wr

	task automatic wr(input logic [7:0] code, input logic [7:0] arg);
		bus_wr(tscc_pkg::ADDR_CMD, {16'h0000, code, arg});
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask : rd

	task automatic settle(input logic [15:0] ang);
		@(posedge i_clk);
		i_angle <= ang;
		repeat (4) @(posedge i_clk);
		#1;
	endtask : settle

	task automatic t_reset();
		int n;
		n = 0;
		repeat (8) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (4) begin
			@(posedge i_clk);
			#1;
			n += (o_boot === 1'b1);
		end
		`CHK("boot", 1, n)
		`CHK("baud_def", tscc_pkg::BAUD_DEF, o_baud_code)
		`CHK("div_def", 32'(tscc_pkg::CLK_HZ / tscc_pkg::BAUD2), o_baud_div)
		`CHK("mode_def", 1'b0, o_mode_teach)
		`CHK("idle_rdata", 32'h0, o_rdata)
		rd(tscc_pkg::ADDR_CONFIG);
		`CHK("cfg_def", 32'h22, d)
	endtask : t_reset

	task automatic t_errors();
		logic [15:0] bad [9];
		bad = '{16'h0130, 16'h0138, 16'h0237, 16'h0332, 16'h0433,
			16'h0930, 16'h0141, 16'h0730, 16'h022F};
		foreach (bad[k]) begin
			wr(bad[k][15:8], bad[k][7:0]);
			`CHK("err_valid", 1'b1, o_reply_valid)
			`CHK("err_char", tscc_pkg::CHAR_ERR, o_reply_char)
		end
		bus_wr(8'h20, 32'h0000_0235);
		rd(8'h20);
		`CHK("unmapped", 32'h0, d)
		rd(tscc_pkg::ADDR_CONFIG);
		`CHK("cfg_kept", 32'h22, d)
	endtask : t_errors

	task automatic t_codes();
		int unsigned br [7];
		br = '{tscc_pkg::BAUD0, tscc_pkg::BAUD1, tscc_pkg::BAUD2,
			tscc_pkg::BAUD3, tscc_pkg::BAUD4, tscc_pkg::BAUD5,
			tscc_pkg::BAUD6};
		for (int k = 0; k < 7; k++) begin
			wr(8'h02, 8'h30 + 8'(k));
			`CHK("baud", 3'(k), o_baud_code)
			`CHK("div", 32'(tscc_pkg::CLK_HZ / br[k]), o_baud_div)
			`CHK("no_reply", 1'b0, o_reply_valid)
			wr(8'h01, 8'h31 + 8'(k));
			rd(tscc_pkg::ADDR_CONFIG);
			`CHK("period", 3'(k + 1), d[2:0])
		end
		wr(8'h02, 8'h32);
		wr(8'h01, 8'h32);
	endtask : t_codes

	task automatic t_origin();
		settle(16'd1234);
		wr(8'h05, 8'h30);
		settle(16'd1300);
		`CHK("org_pos", 16'd66, o_position)
		rd(tscc_pkg::ADDR_ORIGIN);
		`CHK("org_reg", 16'd1234, d[15:0])
		wr(8'h06, 8'h30);
		settle(16'd1300);
		`CHK("clr_pos", 16'd1300, o_position)
		wr(8'h04, 8'h31);
		settle(16'd1300);
		`CHK("ccw1", 1'b1, o_ccw)
		`CHK("ccw_pos", 16'(-16'sd1300), o_position)
		wr(8'h04, 8'h32);
		i_tscc_operator.level(1'b1);
		settle(16'd1300);
		`CHK("pin_hi", 1'b1, o_ccw)
		i_tscc_operator.level(1'b0);
		settle(16'd1300);
		`CHK("pin_lo", 1'b0, o_ccw)
		wr(8'h04, 8'h30);
		i_tscc_operator.level(1'b1);
		settle(16'd1300);
		`CHK("pin_off", 1'b0, o_ccw)
		i_tscc_operator.level(1'b0);
	endtask : t_origin

	task automatic t_teach();
		wr(8'h03, 8'h31);
		`CHK("teach", 1'b1, o_mode_teach)
		settle(16'd1000);
		wr(8'h05, 8'h30);
		settle(16'd3000);
		wr(8'h07, 8'h30);
		settle(16'd3000);
		`CHK("span_full", 16'd2000, o_analog_pos)
		rd(tscc_pkg::ADDR_SPAN);
		`CHK("span_reg", {16'd3000, 16'd1000}, d)
		settle(16'd5000);
		`CHK("serial_free", 16'd4000, o_position)
		`CHK("clamp", 16'h07D0, o_analog_pos)
		`CHK("span_len", 16'h07D0, o_analog_span)
		wr(8'h03, 8'h30);
		settle(16'd5000);
		`CHK("preset_scale", 16'hFFFF, o_analog_span)
		wr(8'h03, 8'h31);
		wr(8'h08, 8'h30);
		settle(16'd5000);
		`CHK("clrmax", 16'hFFFF, o_analog_span)
		wr(8'h03, 8'h30);
		wr(8'h06, 8'h30);
	endtask : t_teach

	task automatic t_pins();
		int n;
		settle(16'd500);
		wr(8'h05, 8'h30);
		settle(16'd777);
		i_tscc_operator.hold(1, 100);
		settle(16'd777);
		rd(tscc_pkg::ADDR_ORIGIN);
		`CHK("short_pulse", 16'd500, d[15:0])
		wr(8'h01, 8'h31);
		fork
			i_tscc_operator.hold(1, 2600);
			begin
				repeat (1500) @(posedge i_clk);
				rd(tscc_pkg::ADDR_ORIGIN);
				`CHK("held", 16'd500, d[15:0])
			end
			begin
				n = 0;
				while (o_tx_tick !== 1'b1 && n < 2000) begin
					@(posedge i_clk);
					#1;
					n++;
				end
				n = 0;
				do begin
					@(posedge i_clk);
					#1;
					n++;
				end while (o_tx_tick !== 1'b1 && n < 2000);
				`CHK("tick", tscc_pkg::PER1_US / TDIV, n)
			end
		join
		settle(16'd777);
		rd(tscc_pkg::ADDR_ORIGIN);
		`CHK("locked", 16'd777, d[15:0])
		`CHK("lock_pos", 16'd0, o_position)
		`CHK("mode_kept", 1'b0, o_mode_teach)
		wr(8'h06, 8'h30);
		rd(tscc_pkg::ADDR_ORIGIN);
		`CHK("revoke", tscc_pkg::ORIGIN_DEF, d[15:0])
	endtask : t_pins

	// Teach a counter-clockwise span by the two set pins
	task automatic t_span_pins();
		wr(8'h03, 8'h31);
		settle(16'h0BB8);
		i_tscc_operator.hold(1, 1100);
		settle(16'h0BB8);
		settle(16'h03E8);
		i_tscc_operator.hold(2, 1100);
		settle(16'h03E8);
		settle(16'h09C4);
		rd(tscc_pkg::ADDR_SPAN);
		`CHK("pin_span", {16'h03E8, 16'h0BB8}, d)
		rd(tscc_pkg::ADDR_ORIGIN);
		`CHK("pin_org", 16'h0BB8, d[15:0])
		`CHK("pin_len", 16'h07D0, o_analog_span)
		`CHK("pin_ccw_scale", 16'h01F4, o_analog_pos)
		`CHK("pin_serial", 16'hFE0C, o_position)
		`CHK("pin_mode", 1'b1, o_mode_teach)
		wr(8'h03, 8'h30);
		wr(8'h06, 8'h30);
	endtask : t_span_pins

	initial begin
		i_rstn = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 8'h00;
		i_wdata = 32'h0;
		i_angle = 16'h0000;
		t_reset();
		t_errors();
		t_codes();
		t_origin();
		t_teach();
		t_pins();
		t_span_pins();
		test_done();
	end

	initial begin
		#(4 * 20000);
		errors++;
		test_done();
	end
endmodule : tscc_top_test

`undef CHK
`default_nettype wire
